// ---- cst_ctrl.sv ----
// colour sensor timing, threshold and interrupt qualification control
// How it works
// - integration lasts 256 minus setting steps of 2.4 ms each
// - full-scale count is steps times 1024, saturated at 65535
// - wait period runs in 2.4 ms steps, twelve times longer with long-wait
// - wait setting is two's complement: 256 minus setting steps
// - long-wait bit, configuration bit 1, multiplies wait steps by twelve
// - low and high 16-bit thresholds split into bytes at 0x04 to 0x07
// - clear value below low or above high is out of range, drives pin
// - persistence setting sits in bits 3:0, bits 7:4 reserved
// - persistence zero interrupts at every integration end
// - settings 1-3 need 1-3 results, 4-15 need 5 to 60 by fives
// - analog gain from control bits 1:0: 1x, 4x, 16x, 60x
// - identification register returns fixed code, writes ignored
// - threshold interrupt only while interrupt enable is set
// - special function 00110 clears pending interrupt, self-clearing
module cst_ctrl #(
  parameter int STEP_CYCLES = cst_pkg::STEP_CYCLES,
  parameter logic [7:0] PART_ID = cst_pkg::PART_ID_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port from the serial front end
  input wire cst_pkg::cst_req_t req,
  input wire logic special_function,
  input wire logic [4:0] sf_code,
  output logic [7:0] rdata,
  // enables from the enable register
  input wire logic measure_enable,
  input wire logic wait_enable,
  input wire logic threshold_interrupt_enable,
  // converter interface
  input wire cst_pkg::cst_result_t clear_result,
  output logic integrating,
  output logic integration_done,
  output logic [15:0] full_scale_count,
  output logic [1:0] analog_gain_select,
  // status and pin
  output logic interrupt_pending,
  output logic interrupt_out_n
);
  typedef struct packed {
    logic [7:0] integration_time_setting;
    logic [7:0] wait_time_setting;
    logic [7:0] low_threshold_lower_byte;
    logic [7:0] low_threshold_upper_byte;
    logic [7:0] high_threshold_lower_byte;
    logic [7:0] high_threshold_upper_byte;
    logic [7:0] interrupt_filter_register;
    logic [7:0] configuration;
    logic [7:0] analog_control;
    logic [7:0] rdata;
    cst_pkg::cst_phase_t phase;
    logic [8:0] step_left;
    logic [3:0] sub_left;
    logic done;
    logic [15:0] full_scale;
    logic pending;
    logic pin_n;
    logic integ;
  } cst_state_t;

  cst_state_t s_q;
  cst_state_t s_d;
  logic step_pulse;
  logic qualified;
  logic out_of_range;
  logic [15:0] low_thr;
  logic [15:0] high_thr;

  function automatic logic [8:0] steps_of(input logic [7:0] setting);
    steps_of = 9'(cst_pkg::STEPS_FULL) - {1'b0, setting};
  endfunction

  cst_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(s_q.phase != cst_pkg::CST_IDLE),
    .step_pulse(step_pulse)
  );

  assign low_thr = {s_q.low_threshold_upper_byte, s_q.low_threshold_lower_byte};
  assign high_thr = {s_q.high_threshold_upper_byte, s_q.high_threshold_lower_byte};
  assign out_of_range = (clear_result.clear_value < low_thr) || (clear_result.clear_value > high_thr);

  cst_persist_filter u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .result_valid(clear_result.valid),
    .out_of_range(out_of_range),
    .setting(s_q.interrupt_filter_register[cst_pkg::FILTER_LSB +: cst_pkg::FILTER_W]),
    .qualified(qualified)
  );

  always_comb begin
    logic [25:0] scale;
    scale = 26'(steps_of(s_q.integration_time_setting)) * 26'(cst_pkg::COUNTS_PER_STEP);
    s_d = s_q;
    s_d.done = 1'b0;
    // register writes
    if (req.valid && req.write) begin
      if (req.addr == cst_pkg::ADDR_INTEGRATION_TIME) begin
        s_d.integration_time_setting = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_WAIT_TIME) begin
        s_d.wait_time_setting = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_LOW_THR_LO) begin
        s_d.low_threshold_lower_byte = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_LOW_THR_HI) begin
        s_d.low_threshold_upper_byte = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_HIGH_THR_LO) begin
        s_d.high_threshold_lower_byte = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_HIGH_THR_HI) begin
        s_d.high_threshold_upper_byte = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_INTERRUPT_FILTER) begin
        s_d.interrupt_filter_register = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_CONFIGURATION) begin
        s_d.configuration = req.wdata;
      end else if (req.addr == cst_pkg::ADDR_ANALOG_CONTROL) begin
        s_d.analog_control = req.wdata;
      end
    end
    // register reads, registered
    if (req.valid && !req.write) begin
      if (req.addr == cst_pkg::ADDR_INTEGRATION_TIME) begin
        s_d.rdata = s_q.integration_time_setting;
      end else if (req.addr == cst_pkg::ADDR_WAIT_TIME) begin
        s_d.rdata = s_q.wait_time_setting;
      end else if (req.addr == cst_pkg::ADDR_LOW_THR_LO) begin
        s_d.rdata = s_q.low_threshold_lower_byte;
      end else if (req.addr == cst_pkg::ADDR_LOW_THR_HI) begin
        s_d.rdata = s_q.low_threshold_upper_byte;
      end else if (req.addr == cst_pkg::ADDR_HIGH_THR_LO) begin
        s_d.rdata = s_q.high_threshold_lower_byte;
      end else if (req.addr == cst_pkg::ADDR_HIGH_THR_HI) begin
        s_d.rdata = s_q.high_threshold_upper_byte;
      end else if (req.addr == cst_pkg::ADDR_INTERRUPT_FILTER) begin
        s_d.rdata = s_q.interrupt_filter_register;
      end else if (req.addr == cst_pkg::ADDR_CONFIGURATION) begin
        s_d.rdata = s_q.configuration;
      end else if (req.addr == cst_pkg::ADDR_ANALOG_CONTROL) begin
        s_d.rdata = s_q.analog_control;
      end else if (req.addr == cst_pkg::ADDR_PART_IDENTIFICATION) begin
        s_d.rdata = PART_ID;
      end else begin
        s_d.rdata = cst_pkg::RESET_BYTE;
      end
    end
    // measurement sequencer
    case (s_q.phase)
      cst_pkg::CST_IDLE: begin
        if (measure_enable) begin
          s_d.phase = cst_pkg::CST_INTEG;
          s_d.step_left = steps_of(s_q.integration_time_setting);
        end
      end
      cst_pkg::CST_INTEG: begin
        if (!measure_enable) begin
          s_d.phase = cst_pkg::CST_IDLE;
        end else if (step_pulse) begin
          if (s_q.step_left == 9'h001) begin
            s_d.done = 1'b1;
            if (wait_enable) begin
              s_d.phase = cst_pkg::CST_WAIT;
              s_d.step_left = steps_of(s_q.wait_time_setting);
              s_d.sub_left = s_q.configuration[cst_pkg::LONG_WAIT_BIT] ?
                4'(cst_pkg::LONG_WAIT_FACTOR) : 4'h1;
            end else begin
              s_d.step_left = steps_of(s_q.integration_time_setting);
            end
          end else begin
            s_d.step_left = s_q.step_left - 9'h001;
          end
        end
      end
      cst_pkg::CST_WAIT: begin
        if (!measure_enable) begin
          s_d.phase = cst_pkg::CST_IDLE;
        end else if (step_pulse) begin
          if (s_q.sub_left != 4'h1) begin
            s_d.sub_left = s_q.sub_left - 4'h1;
          end else if (s_q.step_left == 9'h001) begin
            s_d.phase = cst_pkg::CST_INTEG;
            s_d.step_left = steps_of(s_q.integration_time_setting);
          end else begin
            s_d.step_left = s_q.step_left - 9'h001;
            s_d.sub_left = s_q.configuration[cst_pkg::LONG_WAIT_BIT] ?
              4'(cst_pkg::LONG_WAIT_FACTOR) : 4'h1;
          end
        end
      end
      default: begin
        s_d.phase = cst_pkg::CST_IDLE;
      end
    endcase
    s_d.integ = (s_d.phase == cst_pkg::CST_INTEG);
    // full-scale limit
    if (scale > 26'(cst_pkg::FULL_SCALE_MAX)) begin
      s_d.full_scale = cst_pkg::FULL_SCALE_MAX;
    end else begin
      s_d.full_scale = scale[15:0];
    end
    // interrupt: set wins over clear
    if (special_function && sf_code == cst_pkg::SF_CLEAR_INTERRUPT) begin
      s_d.pending = 1'b0;
    end
    if (qualified && threshold_interrupt_enable) begin
      s_d.pending = 1'b1;
    end
    s_d.pin_n = !s_d.pending;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.integration_time_setting <= cst_pkg::RESET_INTEGRATION;
      s_q.wait_time_setting <= cst_pkg::RESET_WAIT;
      s_q.high_threshold_lower_byte <= cst_pkg::RESET_THR_HI;
      s_q.high_threshold_upper_byte <= cst_pkg::RESET_THR_HI;
      s_q.full_scale <= 16'(cst_pkg::COUNTS_PER_STEP);
      s_q.phase <= cst_pkg::CST_IDLE;
      s_q.pin_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign integrating = s_q.integ;
  assign integration_done = s_q.done;
  assign full_scale_count = s_q.full_scale;
  assign analog_gain_select = s_q.analog_control[cst_pkg::GAIN_LSB +: cst_pkg::GAIN_W];
  assign interrupt_pending = s_q.pending;
  assign interrupt_out_n = s_q.pin_n;
endmodule

// ---- cst_pkg.sv ----
// package: register map, field layout, timing constants and carriers
package cst_pkg;
  localparam logic [4:0] ADDR_INTEGRATION_TIME = 5'h01;
  localparam logic [4:0] ADDR_WAIT_TIME = 5'h03;
  localparam logic [4:0] ADDR_LOW_THR_LO = 5'h04;
  localparam logic [4:0] ADDR_LOW_THR_HI = 5'h05;
  localparam logic [4:0] ADDR_HIGH_THR_LO = 5'h06;
  localparam logic [4:0] ADDR_HIGH_THR_HI = 5'h07;
  localparam logic [4:0] ADDR_INTERRUPT_FILTER = 5'h0c;
  localparam logic [4:0] ADDR_CONFIGURATION = 5'h0d;
  localparam logic [4:0] ADDR_ANALOG_CONTROL = 5'h0f;
  localparam logic [4:0] ADDR_PART_IDENTIFICATION = 5'h12;
  localparam logic [4:0] SF_CLEAR_INTERRUPT = 5'h06;
  localparam int LONG_WAIT_BIT = 1;
  localparam int FILTER_LSB = 0;
  localparam int FILTER_W = 4;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 2;
  localparam int INT_ENABLE_BIT = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_THR_HI = 8'hff;
  localparam logic [7:0] RESET_INTEGRATION = 8'hff;
  localparam logic [7:0] RESET_WAIT = 8'hff;
  localparam logic [7:0] PART_ID_DEFAULT = 8'h5a; // arbitrary value, no real part code
  localparam int STEP_TIME_NS = 2400000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int LONG_WAIT_FACTOR = 12;
  localparam int STEPS_FULL = 256;
  localparam int COUNTS_PER_STEP = 1024;
  localparam logic [15:0] FULL_SCALE_MAX = 16'hffff;
  localparam int MAX_PERSIST = 60;

  typedef enum logic [1:0] {CST_IDLE, CST_INTEG, CST_WAIT} cst_phase_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cst_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] clear_value;
  } cst_result_t;
endpackage

// ---- cst_step_timer.sv ----
// step divider: one-cycle pulse every step of the internal oscillator
module cst_step_timer #(
  parameter int STEP_CYCLES = cst_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic run,
  output logic step_pulse
);
  typedef struct packed {
    logic [15:0] count;
    logic pulse;
  } cst_step_state_t;

  cst_step_state_t s_q;
  cst_step_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!run) begin
      s_d.count = 16'h0000;
    end else if (s_q.count == 16'(STEP_CYCLES - 1)) begin
      s_d.count = 16'h0000;
      s_d.pulse = 1'b1;
    end else begin
      s_d.count = s_q.count + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_pulse = s_q.pulse;
endmodule

// ---- cst_persist_filter.sv ----
// persistence filter: counts consecutive out-of-range results
module cst_persist_filter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // result in
  input wire logic result_valid,
  input wire logic out_of_range,
  input wire logic [3:0] setting,
  // qualified event
  output logic qualified
);
  typedef struct packed {
    logic [5:0] run_count;
    logic hit;
  } cst_filter_state_t;

  cst_filter_state_t s_q;
  cst_filter_state_t s_d;

  function automatic logic [5:0] needed(input logic [3:0] code);
    if (code < 4'h4) begin
      needed = {2'b00, code};
    end else begin
      needed = 6'((code - 4'h3) * 5);
    end
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    if (result_valid) begin
      if (setting == 4'h0) begin
        s_d.hit = 1'b1;
      end else if (!out_of_range) begin
        s_d.run_count = 6'h00;
      end else begin
        if (s_q.run_count < 6'(cst_pkg::MAX_PERSIST)) begin
          s_d.run_count = s_q.run_count + 6'h01;
        end
        if (s_q.run_count + 6'h01 >= needed(setting)) begin
          s_d.hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign qualified = s_q.hit;
endmodule

// ---- cst_ctrl_monitor.sv ----
// checker: port-level timing and value properties of cst_ctrl
module cst_ctrl_monitor #(
  parameter logic [7:0] PART_ID = cst_pkg::PART_ID_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register and result inputs
  input wire cst_pkg::cst_req_t req,
  input wire logic special_function,
  input wire logic [4:0] sf_code,
  input wire logic threshold_interrupt_enable,
  input wire cst_pkg::cst_result_t clear_result,
  // outputs
  input wire logic [7:0] rdata,
  input wire logic integrating,
  input wire logic integration_done,
  input wire logic [15:0] full_scale_count,
  input wire logic [1:0] analog_gain_select,
  input wire logic interrupt_pending,
  input wire logic interrupt_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic wr_ctl;
  logic sf_clr;
  logic [7:0] it_q;
  logic [1:0] age_q;
  assign wr_ctl = req.valid && req.write && req.addr == cst_pkg::ADDR_ANALOG_CONTROL;
  assign sf_clr = special_function && sf_code == cst_pkg::SF_CLEAR_INTERRUPT;
  // last written integration setting and cycles since
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (req.valid && req.write && req.addr == cst_pkg::ADDR_INTEGRATION_TIME)) begin
      it_q <= rst_n ? req.wdata : cst_pkg::RESET_INTEGRATION;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  function automatic logic [15:0] fs(input logic [7:0] t);
    logic [18:0] p;
    p = (19'h0_0100 - {11'h000, t}) << 10;
    return p > 19'h0_ffff ? 16'hffff : p[15:0];
  endfunction
  property p_gain_cause;
    $changed(analog_gain_select) |-> $past(wr_ctl) || $past(wr_ctl, 2);
  endproperty
  a_gain_cause: assert property (p_gain_cause) else $error("gain changed without control write");
  property p_pin;
    interrupt_out_n == !interrupt_pending;
  endproperty
  a_pin: assert property (p_pin) else $error("pin disagrees with pending");
  property p_set_cause;
    $rose(interrupt_pending) |-> $past(clear_result.valid, 2);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("pending set without result");
  property p_set_enable;
    $rose(interrupt_pending) |-> $past(threshold_interrupt_enable);
  endproperty
  a_set_enable: assert property (p_set_enable) else $error("pending set while disabled");
  property p_clear;
    sf_clr && !clear_result.valid && !$past(clear_result.valid) && !$past(clear_result.valid, 2)
      |-> ##[1:2] !interrupt_pending;
  endproperty
  a_clear: assert property (p_clear) else $error("clear command ignored");
  property p_hold;
    interrupt_pending && !sf_clr && !$past(sf_clr) |=> interrupt_pending;
  endproperty
  a_hold: assert property (p_hold) else $error("pending dropped without clear");
  property p_done_pulse;
    integration_done |=> !integration_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_done_end;
    integration_done |-> $past(integrating);
  endproperty
  a_done_end: assert property (p_done_end) else $error("done without integration");
  property p_full_scale;
    age_q == 2'h3 |-> full_scale_count == fs(it_q);
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale count wrong");
  property p_id_read;
    $past(req.valid && !req.write && req.addr == cst_pkg::ADDR_PART_IDENTIFICATION) |-> rdata == PART_ID;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identification read wrong");
  c_set: cover property ($rose(interrupt_pending));
  c_clear: cover property (sf_clr ##1 !interrupt_pending);
  c_done: cover property (integration_done);
endmodule

bind cst_ctrl cst_ctrl_monitor #(.PART_ID(PART_ID)) i_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
  .special_function(special_function), .sf_code(sf_code), .threshold_interrupt_enable(threshold_interrupt_enable),
  .clear_result(clear_result), .rdata(rdata), .integrating(integrating), .integration_done(integration_done),
  .full_scale_count(full_scale_count), .analog_gain_select(analog_gain_select),
  .interrupt_pending(interrupt_pending), .interrupt_out_n(interrupt_out_n));

// ---- cst_host_model.sv ----
// host model: register accesses and special-function commands
module cst_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output cst_pkg::cst_req_t req,
  output logic special_function,
  output logic [4:0] sf_code,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req = '{1'b0, 1'b0, 5'h1f, 8'h00};
    special_function = 1'b0;
    sf_code = 5'h00;
  end
  // one-cycle access, idle fields inverted after release
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] m;
    m = a == cst_pkg::ADDR_CONFIGURATION ? 8'h02 : a == cst_pkg::ADDR_ANALOG_CONTROL ? 8'h03 : 8'hff;
    m = a == cst_pkg::ADDR_INTERRUPT_FILTER ? 8'h0f : m;
    @(negedge clk_sys);
    req = '{1'b1, w, a, d & m};
    @(negedge clk_sys);
    q = rdata;
    req = '{1'b0, ~w, ~a, ~(d & m)};
  endtask
  // one-cycle special-function strobe with any code
  task automatic sf_cmd(input logic [4:0] c);
    @(negedge clk_sys);
    special_function = 1'b1;
    sf_code = c;
    @(negedge clk_sys);
    special_function = 1'b0;
    sf_code = ~c;
  endtask
  task automatic clear_irq();
    sf_cmd(cst_pkg::SF_CLEAR_INTERRUPT);
  endtask
endmodule

// ---- cst_ctrl_test.sv ----
// testbench: registers, persistence filter, interrupt and timing
module cst_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEPC = 4;
  logic clk_sys, rst_n, measure_enable, wait_enable, threshold_interrupt_enable;
  logic special_function, integrating, integration_done, interrupt_pending, interrupt_out_n;
  logic [4:0] sf_code;
  logic [7:0] rdata, q, v;
  logic [15:0] full_scale_count, lo, hi;
  logic [1:0] analog_gain_select;
  cst_pkg::cst_req_t req;
  cst_pkg::cst_result_t clear_result;
  int failures = 0;
  int check_count = 0;
  int base, n, need;
  logic [4:0] ra [11] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d, 5'h0f, 5'h12, 5'h02};
  logic [7:0] rv [11] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00};
  cst_host_model i_host (.clk_sys(clk_sys), .req(req), .special_function(special_function), .sf_code(sf_code),
    .rdata(rdata));
  cst_ctrl #(.STEP_CYCLES(STEPC)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .special_function(special_function), .sf_code(sf_code), .rdata(rdata), .measure_enable(measure_enable),
    .wait_enable(wait_enable), .threshold_interrupt_enable(threshold_interrupt_enable),
    .clear_result(clear_result), .integrating(integrating), .integration_done(integration_done),
    .full_scale_count(full_scale_count), .analog_gain_select(analog_gain_select),
    .interrupt_pending(interrupt_pending), .interrupt_out_n(interrupt_out_n));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d, q);
  endtask
  function automatic logic [7:0] wmask(input logic [4:0] a);
    return a == 5'h0c ? 8'h0f : a == 5'h0d ? 8'h02 : a == 5'h0f ? 8'h03 : 8'hff;
  endfunction
  function automatic logic [15:0] fs_exp(input logic [7:0] t);
    int p;
    p = (256 - int'(t)) * 1024;
    return p > 65535 ? 16'hffff : 16'(p);
  endfunction
  function automatic logic [15:0] outv();
    return $urandom_range(1) ? lo - 16'h0001 - 16'($urandom_range(32)) : hi + 16'h0001 + 16'($urandom_range(32));
  endfunction
  task automatic res(input logic [15:0] d);
    @(negedge clk_sys);
    clear_result = '{1'b1, d};
    @(negedge clk_sys);
    clear_result = '{1'b0, ~d};
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic to_done(output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (integration_done !== 1'b1 && k < 20000);
    if (k == 20000) begin
      failures++;
      summarize();
    end
  endtask
  task automatic timing(input logic [7:0] it, input logic [7:0] wt, input logic lw, input logic we, output int k);
    measure_enable = 1'b0;
    wait_enable = we;
    wr(cst_pkg::ADDR_INTEGRATION_TIME, it);
    wr(cst_pkg::ADDR_WAIT_TIME, wt);
    wr(cst_pkg::ADDR_CONFIGURATION, {6'h00, lw, 1'b0});
    measure_enable = 1'b1;
    to_done(k);
    to_done(k);
  endtask
  initial begin
    rst_n = 1'b0;
    measure_enable = 1'b0;
    wait_enable = 1'b0;
    threshold_interrupt_enable = 1'b0;
    clear_result = '{1'b0, 16'h0000};
    void'($urandom(54923));
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 11; i++) begin
      i_host.access(1'b0, ra[i], 8'h00, q);
      chk("reset value", 16'(q), 16'(rv[i]));
    end
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom);
      wr(ra[i], v);
      i_host.access(1'b0, ra[i], 8'h00, q);
      chk("readback", 16'(q), 16'(i == 9 ? 8'h5a : v & wmask(ra[i])));
    end
    for (int g = 0; g < 4; g++) begin
      wr(cst_pkg::ADDR_ANALOG_CONTROL, 8'($urandom) & 8'hfc | 8'(g));
      repeat (2) @(negedge clk_sys);
      chk("gain", 16'(analog_gain_select), 16'(g));
    end
    foreach (rv[i]) begin
      v = i < 4 ? rv[i] ^ 8'h3e : 8'($urandom);
      wr(cst_pkg::ADDR_INTEGRATION_TIME, v);
      repeat (2) @(negedge clk_sys);
      chk("full scale", full_scale_count, fs_exp(v));
    end
    $display("test registers done");
    lo = 16'h1000 + 16'($urandom_range(16'h6fff));
    hi = 16'h8000 + 16'($urandom_range(16'h6fff));
    wr(5'h04, lo[7:0]);
    wr(5'h05, lo[15:8]);
    wr(5'h06, hi[7:0]);
    wr(5'h07, hi[15:8]);
    wr(cst_pkg::ADDR_INTERRUPT_FILTER, 8'h01);
    res(outv());
    chk("pin disabled", 16'(interrupt_out_n), 16'h0001);
    threshold_interrupt_enable = 1'b1;
    for (int s = 0; s < 16; s++) begin
      need = s < 4 ? s : (s - 3) * 5;
      wr(cst_pkg::ADDR_INTERRUPT_FILTER, 8'(s));
      res(lo);
      chk("every cycle", 16'(interrupt_pending), 16'(s == 0));
      i_host.clear_irq();
      @(negedge clk_sys);
      chk("cleared", 16'(interrupt_pending), 16'h0000);
      if (s > 0) begin
        repeat (need - 1) res(outv());
        res(hi);
        repeat (need - 1) res(outv());
        chk("pin early", 16'(interrupt_out_n), 16'h0001);
        res(outv());
        chk("pin set", 16'(interrupt_out_n), 16'h0000);
        i_host.sf_cmd(5'h07);
        res(lo);
        chk("sticky", 16'(interrupt_pending), 16'h0001);
        i_host.clear_irq();
      end
    end
    $display("test persistence done");
    timing(8'hff, 8'hff, 1'b0, 1'b0, base);
    timing(8'hfd, 8'hff, 1'b0, 1'b0, n);
    chk("integration span", 16'(n - base), 16'(2 * STEPC));
    timing(8'h00, 8'hff, 1'b0, 1'b0, n);
    chk("integration span", 16'(n - base), 16'(255 * STEPC));
    timing(8'hff, 8'hff, 1'b0, 1'b1, base);
    timing(8'hff, 8'hfe, 1'b0, 1'b1, n);
    chk("wait span", 16'(n - base), 16'(STEPC));
    timing(8'hff, 8'hff, 1'b1, 1'b1, n);
    chk("long wait span", 16'(n - base), 16'(11 * STEPC));
    timing(8'hff, 8'h00, 1'b1, 1'b1, n);
    chk("long wait span", 16'(n - base), 16'(3071 * STEPC));
    $display("test timing done");
    summarize();
  end
endmodule
